// >>> inc/ep_mode_cfg.svh
// Offsets, field positions, reset values and mode codes for the endpoint mode responder.
// Assumes inclusion by its bare name; holds definitions only.
`ifndef EP_MODE_CFG_SVH
`define EP_MODE_CFG_SVH

// Register offsets (4-bit register address)
`define REG_MODE0          4'h0
`define REG_MODE1          4'h1
`define REG_MODE2          4'h2
`define REG_COUNT0         4'h3
`define REG_COUNT1         4'h4
`define REG_COUNT2         4'h5
`define REG_TOKSTAT        4'h6
`define REG_INTSTAT        4'h7
`define REG_INTMASK        4'h8

// Field positions
`define STALL_BIT          7
`define MODE_MSB           3
`define COUNT_MSB          3
`define TOK_SETUP_BIT      0
`define TOK_IN_BIT         1
`define TOK_OUT_BIT        2

// Reset values
`define MODE_RESET         4'h0
`define BYTE_RESET         8'h00

// Mode codes
`define M_DISABLE          4'h0
`define M_NAK_INOUT        4'h1
`define M_STATUS_OUT       4'h2
`define M_STALL_INOUT      4'h3
`define M_IGNORE_INOUT     4'h4
`define M_RSV5             4'h5
`define M_STATUS_IN        4'h6
`define M_RSV7             4'h7
`define M_NAK_OUT          4'h8
`define M_ACK_OUT          4'h9
`define M_NAKOUT_STATIN    4'hA
`define M_ACKOUT_NAKIN     4'hB
`define M_NAK_IN           4'hC
`define M_ACK_IN           4'hD
`define M_NAKIN_STATOUT    4'hE
`define M_ACKIN_STATOUT    4'hF

// Status-stage OUT must carry this toggle
`define STATUS_TOGGLE      1'b1

`endif

// >>> inc/ep_mode_pkg.sv
// Types for the endpoint mode responder.
// Assumes ep_mode_cfg.svh is compiled alongside for the numeric constants.
package ep_mode_pkg;

  // Token kinds from the serial interface engine
  typedef enum logic [2:0] {
    TOK_SETUP = 3'h1,
    TOK_IN    = 3'h2,
    TOK_OUT   = 3'h4
  } token_t;

  // Answer kinds to the packet layer
  typedef enum logic [6:0] {
    ANS_NONE  = 7'h01,
    ANS_ACK   = 7'h02,
    ANS_NAK   = 7'h04,
    ANS_STALL = 7'h08,
    ANS_TXCNT = 7'h10,
    ANS_TX0   = 7'h20,
    ANS_IDLE  = 7'h40
  } answer_t;

  // Incoming token with its data-stage facts
  typedef struct packed {
    logic       valid;
    logic [1:0] endpoint;
    token_t     kind;
    logic       zeroLength;
    logic       toggle;
  } token_in_t;

  // Outgoing answer
  typedef struct packed {
    logic       valid;
    logic [1:0] endpoint;
    answer_t    kind;
    logic [3:0] byteCount;
  } answer_out_t;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  // Whole state of the responder
  typedef struct packed {
    logic [2:0][7:0] mode;
    logic [2:0][3:0] count;
    logic [2:0]      tokStat;
    logic [2:0]      intStat;
    logic [2:0]      intMask;
    logic [7:0]      rdata;
    logic            irq;
    answer_out_t     answer;
  } state_t;

endpackage

// >>> src/usb_endpoint_mode_responder.sv
// Handshake policy for one control endpoint and two data endpoints.
// Assumes tokens arrive synchronous to clock as single-cycle strobes; the packet
// layer reports a host ACK to our transmitted data through hostAck.
`timescale 1ns/100ps
`include "ep_mode_cfg.svh"

// Overview of operation
// - Mode 0000 disables an endpoint; all tokens ignored, no handshake.
// - Control endpoint ACK to SETUP forces mode 0001 unless mode is 0000.
// - Mode 0001 ACKs SETUP and NAKs every IN and OUT.
// - Mode 1011 ACKing an OUT changes mode to 0001.
// - Mode 1001 ACKing an OUT goes to 1000; 1000 NAKs OUT only.
// - Mode 1101 acknowledged IN goes to 1100; 1100 NAKs IN only.
// - Mode 1111 acknowledged IN goes to 1110; 1110 accepts SETUP, NAKs IN, checks OUT.
// - Data endpoint stall bit 7 turns 1001 OUT and 1101 IN into STALL.
// - Checked OUT is ACKed only if zero length with toggle 1, else STALL.
// - Transmit-count modes send the byte count from count register bits [3:0].
// - Modes 0110 and 1010 answer IN with a zero-length packet.
// - Ignored tokens produce no handshake at all.
// - Every SETUP-accepting mode ACKs a valid SETUP.
// - Modes 0010, 0011, 0100, 0110, 1010, 1011 answer as tabulated.
// - Reset puts every mode to 0000; the engine never leaves 0000 itself.
// - Control endpoint keeps SETUP, IN and OUT received-token flags.
module usb_endpoint_mode_responder (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    clockEnable,
  input  wire ep_mode_pkg::bus_req_t   busReq,
  output logic [7:0]                   busRdata,
  input  wire ep_mode_pkg::token_in_t  token,
  input  wire logic                    hostAck,
  input  wire logic [1:0]              hostAckEndpoint,
  output ep_mode_pkg::answer_out_t     answer,
  output logic                         irq
);

  ep_mode_pkg::state_t state_q;
  ep_mode_pkg::state_t state_d;

  // ----------------------------------------------------------------
  // Answer decode
  // ----------------------------------------------------------------

  // Pure table lookup from mode, stall and token to the answer
  function automatic ep_mode_pkg::answer_t decide(
    input logic [3:0]          md,
    input logic                stall,
    input ep_mode_pkg::token_t kind,
    input logic                checkOk
  );
    ep_mode_pkg::answer_t a;
    logic                 setupOk;
    a       = ep_mode_pkg::ANS_NONE;
    setupOk = (md == `M_NAK_INOUT) || (md == `M_STATUS_OUT) || (md == `M_STALL_INOUT) ||
              (md == `M_IGNORE_INOUT) || (md == `M_STATUS_IN) || (md == `M_NAKOUT_STATIN) ||
              (md == `M_ACKOUT_NAKIN) || (md == `M_NAKIN_STATOUT) || (md == `M_ACKIN_STATOUT);
    case (kind)
      ep_mode_pkg::TOK_SETUP:
      begin
        a = setupOk ? ep_mode_pkg::ANS_ACK : ep_mode_pkg::ANS_NONE;
      end
      ep_mode_pkg::TOK_IN:
      begin
        case (md)
          `M_NAK_INOUT, `M_ACKOUT_NAKIN, `M_NAK_IN, `M_NAKIN_STATOUT:
          begin
            a = ep_mode_pkg::ANS_NAK;
          end
          `M_STATUS_OUT, `M_STALL_INOUT:
          begin
            a = ep_mode_pkg::ANS_STALL;
          end
          `M_STATUS_IN, `M_NAKOUT_STATIN:
          begin
            a = ep_mode_pkg::ANS_TX0;
          end
          `M_RSV7, `M_ACKIN_STATOUT:
          begin
            a = ep_mode_pkg::ANS_TXCNT;
          end
          `M_ACK_IN:
          begin
            a = stall ? ep_mode_pkg::ANS_STALL : ep_mode_pkg::ANS_TXCNT;
          end
          default:
          begin
            a = ep_mode_pkg::ANS_NONE;
          end
        endcase
      end
      ep_mode_pkg::TOK_OUT:
      begin
        case (md)
          `M_NAK_INOUT, `M_NAK_OUT, `M_NAKOUT_STATIN:
          begin
            a = ep_mode_pkg::ANS_NAK;
          end
          `M_STALL_INOUT, `M_STATUS_IN:
          begin
            a = ep_mode_pkg::ANS_STALL;
          end
          `M_RSV5, `M_ACKOUT_NAKIN:
          begin
            a = ep_mode_pkg::ANS_ACK;
          end
          `M_ACK_OUT:
          begin
            a = stall ? ep_mode_pkg::ANS_STALL : ep_mode_pkg::ANS_ACK;
          end
          `M_STATUS_OUT, `M_NAKIN_STATOUT, `M_ACKIN_STATOUT:
          begin
            a = checkOk ? ep_mode_pkg::ANS_ACK : ep_mode_pkg::ANS_STALL;
          end
          default:
          begin
            a = ep_mode_pkg::ANS_NONE;
          end
        endcase
      end
      default:
      begin
        a = ep_mode_pkg::ANS_NONE;
      end
    endcase
    return a;
  endfunction

  // ----------------------------------------------------------------
  // Mode rewrite after a handshake
  // ----------------------------------------------------------------

  // Next mode after our ACK (OUT/SETUP) or the host's ACK (IN)
  function automatic logic [3:0] rewrite(
    input logic [3:0]          md,
    input logic                isControl,
    input ep_mode_pkg::token_t kind,
    input logic                acked
  );
    logic [3:0] n;
    n = md;
    if (acked && (md != `M_DISABLE))
    begin
      if (kind == ep_mode_pkg::TOK_SETUP && isControl)
        n = `M_NAK_INOUT;
      else if (kind == ep_mode_pkg::TOK_OUT && md == `M_ACKOUT_NAKIN)
        n = `M_NAK_INOUT;
      else if (kind == ep_mode_pkg::TOK_OUT && md == `M_ACK_OUT)
        n = `M_NAK_OUT;
      else if (kind == ep_mode_pkg::TOK_IN && md == `M_ACK_IN)
        n = `M_NAK_IN;
      else if (kind == ep_mode_pkg::TOK_IN && md == `M_ACKIN_STATOUT)
        n = `M_NAKIN_STATOUT;
      else
        n = md;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Answer, mode rewrite, token flags, interrupts and register access
  always_comb
  begin
    ep_mode_pkg::answer_t a;
    logic [3:0]           md;
    logic                 stall;
    logic                 checkOk;
    logic [2:0]           events;
    logic [7:0]           ctrlByte;
    state_d = state_q;
    a       = ep_mode_pkg::ANS_IDLE;
    md      = state_q.mode[token.endpoint][`MODE_MSB:0];
    stall   = (token.endpoint != 2'h0) && state_q.mode[token.endpoint][`STALL_BIT];
    checkOk = token.zeroLength && (token.toggle == `STATUS_TOGGLE);
    events  = 3'h0;
    ctrlByte = `BYTE_RESET;

    // Answer idles between tokens; a stale byte count must not linger
    state_d.answer.valid = 1'b0;
    state_d.answer.kind  = ep_mode_pkg::ANS_IDLE;
    state_d.answer.byteCount = 4'h0;

    // Token arrives: answer it and apply rewrites for our own ACKs
    if (token.valid && token.endpoint <= 2'h2)
    begin
      a = decide(md, stall, token.kind, checkOk);
      state_d.answer.valid     = 1'b1;
      state_d.answer.endpoint  = token.endpoint;
      state_d.answer.kind      = a;
      state_d.answer.byteCount = (a == ep_mode_pkg::ANS_TXCNT) ?
                                 state_q.count[token.endpoint] : 4'h0;
      if (token.kind != ep_mode_pkg::TOK_IN)
        state_d.mode[token.endpoint][`MODE_MSB:0] =
          rewrite(md, token.endpoint == 2'h0, token.kind, a == ep_mode_pkg::ANS_ACK);
      if (token.endpoint == 2'h0 && md != `M_DISABLE)
      begin
        state_d.tokStat = token.kind;
      end
      if (a != ep_mode_pkg::ANS_NONE)
        events[token.endpoint] = 1'b1;
    end

    // Host acknowledged our IN data
    if (hostAck && hostAckEndpoint <= 2'h2)
    begin
      state_d.mode[hostAckEndpoint][`MODE_MSB:0] =
        rewrite(state_q.mode[hostAckEndpoint][`MODE_MSB:0], hostAckEndpoint == 2'h0,
                ep_mode_pkg::TOK_IN, 1'b1);
    end

    // Register writes; bit 7 of the control mode has no stall meaning
    if (busReq.wr)
    begin
      case (busReq.addr)
        `REG_MODE0:
        begin
          state_d.mode[0] = {4'h0, busReq.wdata[`MODE_MSB:0]};
        end
        `REG_MODE1:
        begin
          state_d.mode[1] = {busReq.wdata[`STALL_BIT], 3'h0, busReq.wdata[`MODE_MSB:0]};
        end
        `REG_MODE2:
        begin
          state_d.mode[2] = {busReq.wdata[`STALL_BIT], 3'h0, busReq.wdata[`MODE_MSB:0]};
        end
        `REG_COUNT0:
        begin
          state_d.count[0] = busReq.wdata[`COUNT_MSB:0];
        end
        `REG_COUNT1:
        begin
          state_d.count[1] = busReq.wdata[`COUNT_MSB:0];
        end
        `REG_COUNT2:
        begin
          state_d.count[2] = busReq.wdata[`COUNT_MSB:0];
        end
        `REG_TOKSTAT:
        begin
          state_d.tokStat = state_q.tokStat & ~busReq.wdata[2:0];
        end
        `REG_INTSTAT:
        begin
          state_d.intStat = state_q.intStat & ~busReq.wdata[2:0];
        end
        `REG_INTMASK:
        begin
          state_d.intMask = busReq.wdata[2:0];
        end
        // Unmapped places are ignored
        default:
        begin
          state_d.intMask = state_q.intMask;
        end
      endcase
    end

    // Event sets win over a same-cycle clear
    state_d.intStat = state_d.intStat | events;
    if (token.valid && token.endpoint == 2'h0 && md != `M_DISABLE)
      state_d.tokStat = token.kind;

    // Register reads, data stand one cycle later
    ctrlByte = `BYTE_RESET;
    if (busReq.rd)
    begin
      case (busReq.addr)
        `REG_MODE0:
        begin
          ctrlByte = state_q.mode[0];
        end
        `REG_MODE1:
        begin
          ctrlByte = state_q.mode[1];
        end
        `REG_MODE2:
        begin
          ctrlByte = state_q.mode[2];
        end
        `REG_COUNT0:
        begin
          ctrlByte = {4'h0, state_q.count[0]};
        end
        `REG_COUNT1:
        begin
          ctrlByte = {4'h0, state_q.count[1]};
        end
        `REG_COUNT2:
        begin
          ctrlByte = {4'h0, state_q.count[2]};
        end
        `REG_TOKSTAT:
        begin
          ctrlByte = {5'h00, state_q.tokStat};
        end
        `REG_INTSTAT:
        begin
          ctrlByte = {5'h00, state_q.intStat};
        end
        `REG_INTMASK:
        begin
          ctrlByte = {5'h00, state_q.intMask};
        end
        // Unmapped places read as zero
        default:
        begin
          ctrlByte = `BYTE_RESET;
        end
      endcase
    end
    state_d.rdata = ctrlByte;
    state_d.irq   = |(state_d.intStat & state_d.intMask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // All state resets to disabled and idle; clockEnable freezes everything
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q                  <= '0;
      state_q.answer.kind      <= ep_mode_pkg::ANS_IDLE;
    end
    else if (clockEnable)
    begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops
  assign busRdata = state_q.rdata;
  assign answer   = state_q.answer;
  assign irq      = state_q.irq;

endmodule

// >>> sim/usb_host_model.sv
// Host stand-in: sends tokens when asked and ACKs every data packet it gets.
// Assumes the bench calls send only after reset has been released.
`timescale 1ns/100ps
module usb_host_model (
  input  wire logic                     clock,
  input  wire ep_mode_pkg::answer_out_t answer,
  output ep_mode_pkg::token_in_t        token,
  output logic                          hostAck,
  output logic [1:0]                    hostAckEndpoint
);
  // ----
  // Tokens
  // ----
  // Quiet bus at time zero
  initial
  begin
    token = '0;
    hostAck = 1'b0;
    hostAckEndpoint = 2'h0;
  end

  // One token per call, one cycle wide; data facts flip once released
  task automatic send(input logic [1:0] ep, input ep_mode_pkg::token_t kd, input logic zl, input logic tg);
    @(posedge clock);
    token <= '{1'b1, ep, kd, zl, tg};
    @(posedge clock);
    token.valid <= 1'b0;
    token.zeroLength <= ~zl;
    token.toggle <= ~tg;
    // Return once the answer launched at this edge has settled
    #1;
  endtask

  // Host ACK one cycle after any IN data packet
  always @(posedge clock)
  begin
    hostAck <= answer.valid && (answer.kind == ep_mode_pkg::ANS_TXCNT || answer.kind == ep_mode_pkg::ANS_TX0);
    hostAckEndpoint <= answer.endpoint;
  end
endmodule

// >>> sim/ep_mode_assertions.sv
// Port checks for the endpoint mode responder, bound into every instance.
// Assumes one clock; checks pause in reset and while the clock enable is low.
`timescale 1ns/100ps
module ep_mode_assertions (
  input wire logic                     clock,
  input wire logic                     rst_n,
  input wire logic                     clockEnable,
  input wire ep_mode_pkg::bus_req_t    busReq,
  input wire logic [7:0]               busRdata,
  input wire ep_mode_pkg::token_in_t   token,
  input wire ep_mode_pkg::answer_out_t answer,
  input wire logic                     irq
);
  logic [2:0][3:0] cnt_q;
  wire  logic [3:0] cntIdx = busReq.addr - 4'h3;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || !clockEnable);

  // Shadow of the byte counts as software writes them
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      cnt_q <= '0;
    else if (clockEnable && busReq.wr && busReq.addr >= 4'h3 && busReq.addr <= 4'h5)
      cnt_q[cntIdx[1:0]] <= busReq.wdata[3:0];

  // ----
  // Assertions
  // ----
  a_answer_follows: assert property (token.valid && token.endpoint != 2'h3 |=>
    answer.valid && answer.endpoint == $past(token.endpoint)) else $error("token not answered");
  a_bad_endpoint: assert property (token.valid && token.endpoint == 2'h3 |=> !answer.valid)
    else $error("endpoint 3 answered");
  a_quiet_idle: assert property (!token.valid |=> !answer.valid && answer.kind == ep_mode_pkg::ANS_IDLE)
    else $error("answer without token");
  a_setup_ack: assert property (token.valid && token.kind == ep_mode_pkg::TOK_SETUP |=>
    answer.kind inside {ep_mode_pkg::ANS_NONE, ep_mode_pkg::ANS_ACK}) else $error("bad SETUP answer");
  a_out_no_data: assert property (token.valid && token.kind == ep_mode_pkg::TOK_OUT |=>
    !(answer.kind inside {ep_mode_pkg::ANS_TXCNT, ep_mode_pkg::ANS_TX0})) else $error("data sent on OUT");
  a_in_no_ack: assert property (token.valid && token.kind == ep_mode_pkg::TOK_IN |=>
    answer.kind != ep_mode_pkg::ANS_ACK) else $error("IN acknowledged");
  a_count_value: assert property (answer.valid && answer.kind == ep_mode_pkg::ANS_TXCNT |->
    answer.byteCount == cnt_q[answer.endpoint]) else $error("wrong byte count");
  a_count_zero: assert property (answer.kind != ep_mode_pkg::ANS_TXCNT |-> answer.byteCount == 4'h0)
    else $error("stray byte count");
  a_reset_quiet: assert property ($rose(rst_n) |-> !answer.valid && busRdata == 8'h00 && !irq)
    else $error("outputs busy after reset");

  // Main scenarios
  c_txcnt: cover property (answer.valid && answer.kind == ep_mode_pkg::ANS_TXCNT);
  c_stall: cover property (answer.valid && answer.kind == ep_mode_pkg::ANS_STALL);
  c_irq: cover property ($rose(irq));
endmodule

bind usb_endpoint_mode_responder ep_mode_assertions chk (
  .clock(clock), .rst_n(rst_n), .clockEnable(clockEnable), .busReq(busReq),
  .busRdata(busRdata), .token(token), .answer(answer), .irq(irq)
);

// >>> sim/testbench.sv
// Self-checking bench for the endpoint mode responder.
// Assumes the host model issues tokens and the register bus never waits.
`timescale 1ns/100ps
`include "ep_mode_cfg.svh"
module testbench;
  logic                     clock = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     clockEnable = 1'b1;
  ep_mode_pkg::bus_req_t    busReq = '0;
  ep_mode_pkg::token_in_t   token;
  ep_mode_pkg::answer_out_t answer;
  logic [7:0]               busRdata;
  logic [7:0]               rdVal;
  logic                     hostAck;
  logic [1:0]               hostAckEndpoint;
  logic                     irq;
  logic [3:0]               cnt [3] = '{4'h7, 4'hF, 4'h0};
  int                       n_errors = 0;
  int                       num_checks = 0;
  // Endpoint, mode, token, {zero length, toggle}, answer, mode after
  logic [35:0]              rows [] = '{
    36'h0_00_1_0_01_00, 36'h0_00_4_0_01_00, 36'h0_01_2_0_04_01, 36'h0_01_4_0_04_01,
    36'h0_02_1_0_02_01, 36'h0_02_2_0_08_02, 36'h0_02_4_3_02_02, 36'h0_02_4_1_08_02,
    36'h0_02_4_2_08_02, 36'h0_03_2_0_08_03, 36'h0_03_4_0_08_03, 36'h0_04_2_0_01_04,
    36'h0_04_1_0_02_01, 36'h0_06_2_0_20_06, 36'h0_06_4_0_08_06, 36'h0_0A_2_0_20_0A,
    36'h0_0A_4_0_04_0A, 36'h0_0B_2_0_04_0B, 36'h0_0B_4_0_02_01, 36'h0_0E_2_0_04_0E,
    36'h0_0E_1_0_02_01, 36'h0_0F_2_0_10_0E, 36'h1_09_4_0_02_08, 36'h1_08_4_0_04_08,
    36'h1_08_1_0_01_08, 36'h1_89_4_0_08_89, 36'h1_0D_2_0_10_0C, 36'h1_0C_4_0_01_0C,
    36'h2_8D_2_0_08_8D, 36'h2_0D_2_0_10_0C, 36'h2_00_1_0_01_00};

  // Clock at 50 MHz
  always #10 clock = ~clock;

  usb_endpoint_mode_responder dut (
    .clock(clock), .rst_n(rst_n), .clockEnable(clockEnable), .busReq(busReq), .busRdata(busRdata), .token(token),
    .hostAck(hostAck), .hostAckEndpoint(hostAckEndpoint), .answer(answer), .irq(irq));
  usb_host_model host (
    .clock(clock), .answer(answer), .token(token), .hostAck(hostAck), .hostAckEndpoint(hostAckEndpoint));

  // ----
  // Tasks
  // ----
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [3:0] a);
    @(posedge clock);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1 rdVal = busRdata;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    stop_test;
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 9; a++)
    begin
      rdReg(4'(a));
      check(rdVal === 8'h00 && irq === 1'b0, "reset value");
    end
    wr(`REG_COUNT0, 8'h07);
    wr(`REG_COUNT1, 8'h0F);
    foreach (rows[i])
    begin
      wr(rows[i][35:32], rows[i][31:24]);
      host.send(rows[i][33:32], ep_mode_pkg::token_t'(rows[i][22:20]), rows[i][17], rows[i][16]);
      check(answer.valid === 1'b1 && answer.kind === rows[i][14:8], "answer kind");
      if (rows[i][14:8] == 7'h10)
        check(answer.byteCount === cnt[rows[i][33:32]], "byte count");
      repeat (2) @(posedge clock);
      rdReg(rows[i][35:32]);
      check(rdVal === rows[i][7:0], "mode after");
    end
    host.send(2'h3, ep_mode_pkg::TOK_IN, 1'b0, 1'b0);
    check(answer.valid === 1'b0, "endpoint 3 answered");
    wr(`REG_MODE0, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      host.send(2'h0, ep_mode_pkg::token_t'(3'h1 << k), 1'b0, 1'b0);
      rdReg(`REG_TOKSTAT);
      check(rdVal === 8'(8'h01 << k), "token flag");
    end
    // Interrupt raised while masked, unmasked, then cleared
    wr(`REG_INTSTAT, 8'h07);
    wr(`REG_INTMASK, 8'h00);
    host.send(2'h0, ep_mode_pkg::TOK_IN, 1'b0, 1'b0);
    rdReg(`REG_INTSTAT);
    check(rdVal === 8'h01 && irq === 1'b0, "masked event");
    wr(`REG_INTMASK, 8'h01);
    @(posedge clock);
    #1 check(irq === 1'b1, "irq not raised");
    wr(`REG_INTSTAT, 8'h01);
    @(posedge clock);
    #1 check(irq === 1'b0, "irq not cleared");
    // Unmapped place; the reset in mid-run follows the clock enable check
    wr(4'hF, 8'hFF);
    rdReg(4'hF);
    check(rdVal === 8'h00, "unmapped read");
    // Clock enable low: a token must leave no trace
    @(posedge clock);
    clockEnable <= 1'b0;
    host.send(2'h0, ep_mode_pkg::TOK_OUT, 1'b0, 1'b0);
    check(answer.valid === 1'b0, "answer while frozen");
    repeat (2) @(posedge clock);
    clockEnable <= 1'b1;
    rdReg(`REG_TOKSTAT);
    check(rdVal === 8'h02, "flags moved while frozen");
    wr(`REG_MODE1, 8'h0D);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    rdReg(`REG_MODE1);
    check(rdVal === 8'h00, "mode kept over reset");
    host.send(2'h1, ep_mode_pkg::TOK_IN, 1'b0, 1'b0);
    check(answer.kind === ep_mode_pkg::ANS_NONE, "disabled endpoint answered");
    stop_test;
  end
endmodule
